// File: cpu_datapath.v
// Sixteen-bit processor datapath: register file, ALU, carry, shifter
`timescale 1ns/1ps
`include "cpu_datapath_defs.vh"
// --------------------------------------------------------------
// --------------------------------------------------------------
module cpu_datapath (
  // Clock and reset
  input  wire        clk_sys,
  input  wire        reset,
  // Register file port one
  input  wire [2:0]  port1ReadAddr,
  input  wire        port1ReadEn,
  input  wire [2:0]  port1WriteAddr,
  input  wire        port1WriteEn,
  // Register file port two
  input  wire [2:0]  port2Addr,
  input  wire        port2ReadEn,
  input  wire        port2WriteEn,
  // Sequencing controls
  input  wire        instrRegLoad,
  input  wire        effectiveAddrState,
  input  wire        inputMuxEn,
  input  wire        dataDriveEn,
  input  wire        carryLoad,
  input  wire        arithLogicClassInstr,
  input  wire [1:0]  procFunc,
  // Timing requests
  input  wire        readModifyWriteStretch,
  input  wire        outputStretch,
  input  wire        slowChannelStretch,
  input  wire        extendPeriod,
  input  wire        memWaitN,
  // Shared data bus, low-true
  input  wire [15:0] dataBusInN,
  output reg  [15:0] dataBusOutN,
  output reg         dataBusOe,
  // Memory and I/O lines
  output reg  [14:0] memAddrOut,
  output wire [5:0]  deviceSelectLinesN,
  // Processor state
  output reg  [15:0] instrReg,
  output wire [15:0] instrRegN,
  output reg         carry,
  output wire        lookaheadCarryResult,
  // Timing
  output wire        baseClock,
  output wire        memClock,
  output wire        timingPhaseA,
  output wire        timingPhaseC,
  output wire        timingPhaseD,
  output wire        stateClock
);

  reg  [15:0] regFile [0:7];
  reg  [15:0] dataMeta;
  reg  [15:0] dataSync;
  reg  [15:0] aluA;
  reg  [15:0] aluB;
  reg         aluInvB;
  reg         aluAnd;
  reg         aluCin;
  reg         baseCarry;
  reg  [1:0]  shiftSel;
  wire [15:0] operandAddressBus;
  wire [15:0] centralBus;
  wire [15:0] inputMuxBus;
  wire [15:0] aluResult;
  wire [15:0] shifterResultBus;
  wire [17:0] shiftExt;
  wire [2:0]  aluFn;
  wire        port2ReadGate;
  wire        carryChain;
  wire        shiftCarry;

  // --------------------------------------------------------------
  // Data bus input synchroniser
  // --------------------------------------------------------------
  // The bus is shared with other boards, so it is resynchronised;
  // this costs two cycles before read data reaches the central bus
  always @(posedge clk_sys) begin
    if (reset) begin
      dataMeta <= 16'h0000;
      dataSync <= 16'h0000;
    end else begin
      dataMeta <= ~dataBusInN;
      dataSync <= dataMeta;
    end
  end

  // --------------------------------------------------------------
  // Register file: one entry per generate pass
  // --------------------------------------------------------------
  genvar r;
  generate
    for (r = 0; r < 8; r = r + 1) begin : rfEntry
      // Pointer and memory address keep fifteen bits only
      localparam [15:0] MASK =
        (r == `RF_INSTR_PTR || r == `RF_MEM_ADDR) ?
        `RF_ADDR_MASK : `RF_FULL_MASK;
      // Port two wins if both ports name the same entry
      always @(posedge clk_sys) begin
        if (reset) begin
          regFile[r] <= `RF_RESET;
        end else if (port2WriteEn && port2Addr == r) begin
          regFile[r] <= shifterResultBus & MASK;
        end else if (port1WriteEn && port1WriteAddr == r) begin
          regFile[r] <= centralBus & MASK;
        end
      end
    end
  endgenerate

  // Read port one onto the operand address bus
  assign operandAddressBus =
    port1ReadEn ? regFile[port1ReadAddr] : 16'h0000;

  // Single-operand operations keep port two off the bus
  assign port2ReadGate = port2ReadEn &
    ~(arithLogicClassInstr & ~instrReg[`IR_SINGLE_OP]);

  // --------------------------------------------------------------
  // Input multiplexor and central bus
  // --------------------------------------------------------------
  assign inputMuxBus = effectiveAddrState ?
    {{8{instrReg[`IR_DISP_MSB]}}, instrReg[7:0]} : dataSync;

  // Sources are OR-ed, as on the open-collector backplane
  assign centralBus =
    (port2ReadGate ? regFile[port2Addr] : 16'h0000) |
    (inputMuxEn ? inputMuxBus : 16'h0000);

  // --------------------------------------------------------------
  // ALU operand and function selection
  // --------------------------------------------------------------
  assign aluFn = instrReg[`IR_ALU_MSB:`IR_ALU_LSB];

  always @* begin
    aluA    = centralBus;
    aluB    = operandAddressBus;
    aluInvB = 1'b0;
    aluAnd  = 1'b0;
    aluCin  = 1'b0;
    if (arithLogicClassInstr) begin
      // Subtract forms add the complement, carry-in adds the one
      aluInvB = ~aluFn[1];
      aluCin  = aluFn[0];
      aluAnd  = (aluFn == `ALU_AND);
    end else begin
      case (procFunc)
        `PF_PASS_CPB: aluB = 16'h0000;
        `PF_INC: begin
          aluB   = 16'h0000;
          aluCin = 1'b1;
        end
        `PF_DEC:      aluB = 16'hffff;
        `PF_PASS_OPERAND_ADDRESS_BUS: aluA = 16'h0000;
        default:      aluB = 16'h0000;
      endcase
    end
  end

  alu_lookahead #(
    .SLICES (4)
  ) aluUnit (
    .opA      (aluA),
    .opB      (aluB),
    .invertB  (aluInvB),
    .andMode  (aluAnd),
    .carryIn  (aluCin),
    .result   (aluResult),
    .carryOut (carryChain)
  );

  assign lookaheadCarryResult = carryChain;

  // --------------------------------------------------------------
  // Carry set-up: computed, never written here
  // --------------------------------------------------------------
  // Stored carry is the base when the instruction carry code is keep
  always @* begin
    case (instrReg[`IR_CARRY_MSB:`IR_CARRY_LSB])
      `CRY_KEEP: baseCarry = carry;
      `CRY_ZERO: baseCarry = 1'b0;
      `CRY_ONE:  baseCarry = 1'b1;
      `CRY_FLIP: baseCarry = ~carry;
      default:   baseCarry = carry;
    endcase
  end

  // --------------------------------------------------------------
  // Shifter: per-bit four-input selector plus carry stage
  // --------------------------------------------------------------
  always @* begin
    if (arithLogicClassInstr) begin
      shiftSel = instrReg[`IR_SHIFT_MSB:`IR_SHIFT_LSB];
    end else begin
      shiftSel = `SH_NONE;
    end
  end

  // Overflow inverts the base carry before the carry stage
  assign shiftExt = {baseCarry ^ carryChain, aluResult,
                     baseCarry ^ carryChain};

  genvar b;
  generate
    for (b = 0; b < 16; b = b + 1) begin : shiftBit
      reg pick;
      always @* begin
        pick = 1'b0;
        case (shiftSel)
          `SH_NONE:  pick = shiftExt[b+1];
          `SH_LEFT:  pick = shiftExt[b];
          `SH_RIGHT: pick = shiftExt[b+2];
          `SH_SWAP:  pick = aluResult[(b+8)%16];
          default:   pick = shiftExt[b+1];
        endcase
      end
      assign shifterResultBus[b] = pick;
    end
  endgenerate

  // Seventeenth stage: the bit pushed out becomes the new carry
  assign shiftCarry =
    (shiftSel == `SH_LEFT)  ? aluResult[15] :
    (shiftSel == `SH_RIGHT) ? aluResult[0]  :
    shiftExt[0];

  // --------------------------------------------------------------
  // Carry, instruction register and output drivers
  // --------------------------------------------------------------
  always @(posedge clk_sys) begin
    if (reset) begin
      carry <= 1'b0;
    end else if (carryLoad) begin
      carry <= shiftCarry;
    end
  end

  always @(posedge clk_sys) begin
    if (reset) begin
      instrReg <= 16'h0000;
    end else if (instrRegLoad) begin
      instrReg <= centralBus;
    end
  end

  assign instrRegN = ~instrReg;

  // Device select is low-true and follows the register at all times
  assign deviceSelectLinesN = instrRegN[`IR_DS_MSB:0];

  // Registered drivers toward memory and the shared bus
  always @(posedge clk_sys) begin
    if (reset) begin
      memAddrOut  <= 15'h0000;
      dataBusOutN <= 16'hffff;
      dataBusOe   <= 1'b0;
    end else begin
      memAddrOut  <= operandAddressBus[14:0];
      dataBusOutN <= ~centralBus;
      dataBusOe   <= dataDriveEn;
    end
  end

  // --------------------------------------------------------------
  // Timing generator
  // --------------------------------------------------------------
  state_timing timing (
    .clk_sys                (clk_sys),
    .reset                  (reset),
    .readModifyWriteStretch (readModifyWriteStretch),
    .outputStretch          (outputStretch),
    .slowChannelStretch     (slowChannelStretch),
    .extendPeriod           (extendPeriod),
    .memWaitN               (memWaitN),
    .baseClock              (baseClock),
    .memClock               (memClock),
    .timingPhaseA           (timingPhaseA),
    .timingPhaseC           (timingPhaseC),
    .timingPhaseD           (timingPhaseD),
    .stateClock             (stateClock)
  );

endmodule

// File: cpu_datapath_defs.vh
// Shared constants for the sixteen-bit processor datapath and timing
`ifndef CPU_DATAPATH_DEFS_VH
`define CPU_DATAPATH_DEFS_VH

// --------------------------------------------------------------
// Register file addresses
// --------------------------------------------------------------
`define RF_CH_DATA      3'h0
`define RF_INSTR_PTR    3'h1
`define RF_CH_ADDR      3'h2
`define RF_MEM_ADDR     3'h3
`define RF_ACC0         3'h4
`define RF_ACC1         3'h5
`define RF_ACC2         3'h6
`define RF_ACC3         3'h7
`define RF_ADDR_MASK    16'h7fff
`define RF_FULL_MASK    16'hffff
`define RF_RESET        16'h0000

// --------------------------------------------------------------
// Instruction field positions (bit 15 of the word is the MSB)
// --------------------------------------------------------------
`define IR_SINGLE_OP    10
`define IR_ALU_MSB      10
`define IR_ALU_LSB      8
`define IR_SHIFT_MSB    7
`define IR_SHIFT_LSB    6
`define IR_CARRY_MSB    5
`define IR_CARRY_LSB    4
`define IR_DISP_MSB     7
`define IR_DS_MSB       5

// --------------------------------------------------------------
// Operation codes
// --------------------------------------------------------------
`define ALU_AND         3'h7
`define CRY_KEEP        2'h0
`define CRY_ZERO        2'h1
`define CRY_ONE         2'h2
`define CRY_FLIP        2'h3
`define SH_NONE         2'h0
`define SH_LEFT         2'h1
`define SH_RIGHT        2'h2
`define SH_SWAP         2'h3
`define PF_PASS_CPB     2'h0
`define PF_INC          2'h1
`define PF_DEC          2'h2
`define PF_PASS_OPERAND_ADDRESS_BUS    2'h3

// --------------------------------------------------------------
// Timing
// --------------------------------------------------------------
`define SYS_CLK_NS      50
`define BASE_CLK_NS     100
`define STATE_PULSE_NS  100
`define STATE_MIN_NS    300
`define STATE_LONG_NS   400
`define BASE_DIV        (`BASE_CLK_NS / `SYS_CLK_NS)
`define STEPS_MIN       (`STATE_MIN_NS / `BASE_CLK_NS)
`define STEPS_LONG      (`STATE_LONG_NS / `BASE_CLK_NS)

`endif

// File: alu_lookahead.v
// Sixteen-bit ALU from four-bit slices joined by a look-ahead carry unit
`timescale 1ns/1ps
module alu_lookahead #(
  parameter SLICES = 4
) (
  // Operands
  input  wire [4*SLICES-1:0] opA,
  input  wire [4*SLICES-1:0] opB,
  // Controls
  input  wire                invertB,
  input  wire                andMode,
  input  wire                carryIn,
  // Results
  output wire [4*SLICES-1:0] result,
  output wire                carryOut
);

  wire [4*SLICES-1:0] bEff;
  wire [SLICES:0]     chain;
  wire [SLICES-1:0]   sliceGen;
  wire [SLICES-1:0]   slicePro;

  assign bEff     = invertB ? ~opB : opB;
  assign chain[0] = carryIn & ~andMode;
  assign carryOut = chain[SLICES];

  // --------------------------------------------------------------
  // Slices and look-ahead chain
  // --------------------------------------------------------------
  genvar s;
  generate
    for (s = 0; s < SLICES; s = s + 1) begin : slice
      wire [3:0] a;
      wire [3:0] b;
      wire [4:0] gen;
      wire [4:0] pro;
      assign a = opA[4*s+3:4*s];
      assign b = bEff[4*s+3:4*s];
      // Slice generate and propagate come from its own four bits only
      assign gen = {1'b0, a & b} + {1'b0, a | b};
      assign pro = {1'b0, a} + {1'b0, b} + 5'h01;
      assign sliceGen[s] = gen[4] & ~andMode;
      assign slicePro[s] = pro[4] & ~andMode;
      assign result[4*s+3:4*s] = andMode ? (a & b) :
                                 (a + b + {3'h0, chain[s]});
      // Look-ahead: each slice carry from its own generate and propagate and the carry below
      assign chain[s+1] = sliceGen[s] | (slicePro[s] & chain[s]);
    end
  endgenerate

endmodule

// File: state_timing.v
// Base clock divider and state clock timing generator
`timescale 1ns/1ps
`include "cpu_datapath_defs.vh"
module state_timing (
  // Clock and reset
  input  wire clk_sys,
  input  wire reset,
  // Period requests
  input  wire readModifyWriteStretch,
  input  wire outputStretch,
  input  wire slowChannelStretch,
  input  wire extendPeriod,
  // Memory wait, pulled low by a slow memory
  input  wire memWaitN,
  // Timing outputs
  output reg  baseClock,
  output reg  memClock,
  output wire timingPhaseA,
  output wire timingPhaseC,
  output wire timingPhaseD,
  output wire stateClock
);

  reg [3:0] phase;
  reg [3:0] next_phase;
  reg       dwell;
  reg       waitMeta;
  reg       waitSync;
  wire      baseRise;
  wire      stretch;
  wire      frozen;

  // --------------------------------------------------------------
  // Oscillator divide: two complementary squares
  // --------------------------------------------------------------
  always @(posedge clk_sys) begin
    if (reset) begin
      baseClock <= 1'b0;
      memClock  <= 1'b1;
    end else begin
      baseClock <= ~baseClock;
      memClock  <= baseClock;
    end
  end

  // Wait line is a pin, so it is synchronised first
  always @(posedge clk_sys) begin
    if (reset) begin
      waitMeta <= 1'b1;
      waitSync <= 1'b1;
    end else begin
      waitMeta <= memWaitN;
      waitSync <= waitMeta;
    end
  end

  assign baseRise = ~baseClock;
  assign stretch  = readModifyWriteStretch | outputStretch |
                    slowChannelStretch;
  // Hold in the C-D state while the wait line sits low
  assign frozen   = phase[3] & ~waitSync;

  // --------------------------------------------------------------
  // Phase sequence: A C D, or A B C D when stretched
  // --------------------------------------------------------------
  always @* begin
    case (phase)
      4'h1:    next_phase = stretch ? 4'h2 : 4'h4;
      4'h2:    next_phase = 4'h4;
      4'h4:    next_phase = 4'h8;
      4'h8:    next_phase = 4'h1;
      default: next_phase = 4'h1;
    endcase
  end

  // Shift register stepped on a rising base clock, unless frozen or in the extended-period dwell
  always @(posedge clk_sys) begin
    if (reset) begin
      phase <= 4'h1;
      dwell <= 1'b0;
    end else if (baseRise) begin
      if (frozen) begin
        dwell <= 1'b0;
      end else if (extendPeriod && !dwell) begin
        dwell <= 1'b1;
      end else begin
        dwell <= 1'b0;
        phase <= next_phase;
      end
    end
  end

  assign timingPhaseA = phase[0];
  assign timingPhaseC = phase[2] | phase[3];
  assign timingPhaseD = phase[3];
  // One base period wide: all of phase A, or its first half when the period is extended
  assign stateClock   = phase[0] & ~dwell;

endmodule

// File: cpu_datapath_asserts.sv
// Port checker for the processor datapath and its timing generator
`timescale 1ns/1ps
module cpu_datapath_asserts (
  // Clock and reset
  input wire        clk_sys,
  input wire        reset,
  // Controls
  input wire        port1ReadEn,
  input wire        instrRegLoad,
  input wire        inputMuxEn,
  input wire        dataDriveEn,
  input wire        arithLogicClassInstr,
  input wire        readModifyWriteStretch,
  input wire        outputStretch,
  input wire        slowChannelStretch,
  input wire        extendPeriod,
  input wire        memWaitN,
  // Observed outputs
  input wire [15:0] dataBusOutN,
  input wire        dataBusOe,
  input wire [14:0] memAddrOut,
  input wire [5:0]  deviceSelectLinesN,
  input wire [15:0] instrReg,
  input wire [15:0] instrRegN,
  input wire        baseClock,
  input wire        memClock,
  input wire        timingPhaseD,
  input wire        stateClock
);
  // Request mixes that fix the state clock period exactly
  wire anyStretch  = readModifyWriteStretch | outputStretch
                     | slowChannelStretch;
  wire quiet       = !anyStretch && !extendPeriod && memWaitN;
  wire stretchOnly = anyStretch && !extendPeriod && memWaitN;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);

  AST_BASE_CLOCK: assert property (
    $past(reset) || baseClock != $past(baseClock) && memClock != baseClock)
    else $error("base and memory clocks not complementary halves");
  AST_DEV_SELECT: assert property (
    deviceSelectLinesN == ~instrReg[5:0])
    else $error("device select lines differ from instruction bits");
  AST_IR_INVERT: assert property (
    instrRegN == ~instrReg)
    else $error("inverted instruction output wrong");
  AST_IR_HOLD: assert property (
    !instrRegLoad |=> $stable(instrReg))
    else $error("instruction register changed without load");
  AST_ADDR_IDLE: assert property (
    !$past(port1ReadEn) |-> memAddrOut == 15'h0000)
    else $error("memory address driven with port one read off");
  AST_DRIVE_EN: assert property (
    dataBusOe == $past(dataDriveEn))
    else $error("data bus enable does not follow drive request");
  AST_SINGLE_OP: assert property (
    arithLogicClassInstr && !instrReg[10] && !inputMuxEn
    |=> dataBusOutN == 16'hffff)
    else $error("central bus not zero for single operand operation");
  AST_PULSE: assert property (
    $rose(stateClock) |-> stateClock ##1 stateClock ##1 !stateClock)
    else $error("state clock pulse not two cycles wide");
  AST_PERIOD_MIN: assert property (
    $rose(stateClock) && quiet && $past(memWaitN, 1)
    && $past(memWaitN, 2) ##1 quiet [*5] |=> $rose(stateClock))
    else $error("plain state period not six cycles");
  AST_STRETCH: assert property (
    $rose(stateClock) && stretchOnly && $past(memWaitN, 1)
    && $past(memWaitN, 2) ##1 stretchOnly [*5]
    |=> !stateClock [*2] ##1 $rose(stateClock))
    else $error("stretched state period not eight cycles");
  AST_FREEZE: assert property (
    timingPhaseD && !$past(memWaitN, 1) && !$past(memWaitN, 2)
    |=> timingPhaseD)
    else $error("timing left phase D while memory waits");
endmodule

bind cpu_datapath cpu_datapath_asserts chk_u (
  .clk_sys(clk_sys), .reset(reset), .port1ReadEn(port1ReadEn),
  .instrRegLoad(instrRegLoad), .inputMuxEn(inputMuxEn),
  .dataDriveEn(dataDriveEn), .arithLogicClassInstr(arithLogicClassInstr),
  .readModifyWriteStretch(readModifyWriteStretch),
  .outputStretch(outputStretch), .slowChannelStretch(slowChannelStretch),
  .extendPeriod(extendPeriod), .memWaitN(memWaitN),
  .dataBusOutN(dataBusOutN), .dataBusOe(dataBusOe),
  .memAddrOut(memAddrOut), .deviceSelectLinesN(deviceSelectLinesN),
  .instrReg(instrReg), .instrRegN(instrRegN), .baseClock(baseClock),
  .memClock(memClock), .timingPhaseD(timingPhaseD),
  .stateClock(stateClock));

// File: mem_partner.sv
// Memory board model on the shared data bus and the wait line
`timescale 1ns/1ps
module mem_partner #(
  parameter WAIT_LEN = 20
) (
  // Clock
  input  wire        clk_sys,
  // Processor side of the data bus
  input  wire        dataBusOe,
  input  wire [15:0] dataBusOutN,
  // Bench requests
  input  wire        presentEn,
  input  wire [15:0] presentWord,
  input  wire        waitStart,
  // Resolved pins
  output wire [15:0] dataBusInN,
  output wire        memWaitN
);
  reg [7:0] waitCount = 8'h00;

  // Open-collector bus: processor first, then memory, else pull-ups high
  assign dataBusInN = dataBusOe ? dataBusOutN :
                      presentEn ? ~presentWord : 16'hffff;

  // Slow read holds the wait line low, then lets it float high
  always @(posedge clk_sys) begin
    if (waitStart)
      waitCount <= WAIT_LEN;
    else if (waitCount != 8'h00)
      waitCount <= waitCount - 8'h01;
  end
  assign memWaitN = (waitCount == 8'h00);
endmodule

// File: tb.sv
// Self-checking bench for the processor datapath and timing generator
`timescale 1ns/1ps
module tb;
  // --------------------------------------------------------------
  // Signals
  // --------------------------------------------------------------
  reg        clk_sys, reset, port1ReadEn, port1WriteEn, port2ReadEn;
  reg        port2WriteEn, instrRegLoad, effectiveAddrState, inputMuxEn;
  reg        dataDriveEn, carryLoad, arithLogicClassInstr;
  reg        readModifyWriteStretch, outputStretch, slowChannelStretch;
  reg        extendPeriod, present, waitStart, cy;
  reg [2:0]  port1ReadAddr, port1WriteAddr, port2Addr;
  reg [1:0]  procFunc;
  reg [15:0] word, ir, n, rv [0:7];
  reg [16:0] r;
  wire [15:0] dataBusInN, dataBusOutN, instrReg, instrRegN;
  wire [14:0] memAddrOut;
  wire [5:0]  deviceSelectLinesN;
  wire        memWaitN, dataBusOe, carry, stateClock;
  integer     err_total, checked, i;

  cpu_datapath dut_u (.clk_sys(clk_sys), .reset(reset),
    .port1ReadAddr(port1ReadAddr), .port1ReadEn(port1ReadEn),
    .port1WriteAddr(port1WriteAddr), .port1WriteEn(port1WriteEn),
    .port2Addr(port2Addr), .port2ReadEn(port2ReadEn),
    .port2WriteEn(port2WriteEn), .instrRegLoad(instrRegLoad),
    .effectiveAddrState(effectiveAddrState), .inputMuxEn(inputMuxEn),
    .dataDriveEn(dataDriveEn), .carryLoad(carryLoad),
    .arithLogicClassInstr(arithLogicClassInstr), .procFunc(procFunc),
    .readModifyWriteStretch(readModifyWriteStretch),
    .outputStretch(outputStretch), .slowChannelStretch(slowChannelStretch),
    .extendPeriod(extendPeriod), .memWaitN(memWaitN),
    .dataBusInN(dataBusInN), .dataBusOutN(dataBusOutN),
    .dataBusOe(dataBusOe), .memAddrOut(memAddrOut),
    .deviceSelectLinesN(deviceSelectLinesN), .instrReg(instrReg),
    .instrRegN(instrRegN), .carry(carry), .lookaheadCarryResult(),
    .baseClock(), .memClock(), .timingPhaseA(), .timingPhaseC(),
    .timingPhaseD(), .stateClock(stateClock));
  mem_partner mem_u (.clk_sys(clk_sys), .dataBusOe(dataBusOe),
    .dataBusOutN(dataBusOutN), .presentEn(present), .presentWord(word),
    .waitStart(waitStart), .dataBusInN(dataBusInN), .memWaitN(memWaitN));

  // 20 MHz clock
  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end

  // --------------------------------------------------------------
  // Tasks and reference model
  // --------------------------------------------------------------
  task check(input [15:0] seen, input [15:0] exp);
    begin
      checked = checked + 1;
      if (seen !== exp) begin
        err_total = err_total + 1;
        $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
      end
    end
  endtask
  task report_and_stop;
    begin
      if (err_total == 0 && checked > 0)
        $display("STATUS OK");
      else
        $display("STATUS NOT OK");
      $finish;
    end
  endtask
  task idle;
    begin
      {port1ReadEn, port1WriteEn, port2ReadEn, port2WriteEn, instrRegLoad,
       effectiveAddrState, inputMuxEn, dataDriveEn, carryLoad,
       arithLogicClassInstr, procFunc} = 12'h000;
      @(negedge clk_sys);
    end
  endtask
  // Word crosses two sync flops before the input mux can use it
  task put_bus(input [15:0] w);
    begin
      word = w;
      present = 1'b1;
      repeat (3) @(negedge clk_sys);
    end
  endtask
  task write1(input [2:0] a, input [15:0] w);
    begin
      put_bus(w);
      {inputMuxEn, port1WriteEn, port1WriteAddr} = {2'b11, a};
      @(negedge clk_sys);
      idle;
    end
  endtask
  task set_ir(input [15:0] w);
    begin
      put_bus(w);
      {inputMuxEn, instrRegLoad} = 2'b11;
      @(negedge clk_sys);
      idle;
      check(instrReg, w);
      check({10'h000, deviceSelectLinesN}, {10'h000, ~w[5:0]});
    end
  endtask
  // Port two onto the data bus, port one onto the memory address
  task readback(input [2:0] a, input [15:0] exp);
    begin
      {port1ReadEn, port1ReadAddr, port2ReadEn, port2Addr} = {1'b1, a, 1'b1, a};
      dataDriveEn = 1'b1;
      @(negedge clk_sys);
      check(~dataBusInN, exp);
      check({1'b0, memAddrOut}, {1'b0, exp[14:0]});
      idle;
    end
  endtask
  task period(input sync, input [15:0] start);
    begin
      if (sync) begin
        while (stateClock !== 1'b1) @(negedge clk_sys);
        while (stateClock !== 1'b0) @(negedge clk_sys);
        while (stateClock !== 1'b1) @(negedge clk_sys);
      end
      n = start;
      @(negedge clk_sys);
      while (stateClock === 1'b1) begin n = n + 1; @(negedge clk_sys); end
      while (stateClock === 1'b0) begin n = n + 1; @(negedge clk_sys); end
    end
  endtask
  function [15:0] masked(input [2:0] a, input [15:0] w);
    masked = (a == 3'h1 || a == 3'h3) ? (w & 16'h7fff) : w;
  endfunction
  // Arithmetic class result: {new carry, shifter output}
  function [16:0] model(input [15:0] x, input [15:0] m, input [15:0] c,
                        input cin);
    reg [16:0] s;
    reg        b;
    begin
      c = x[10] ? c : 16'h0000;
      s = {1'b0, c} + {1'b0, x[9] ? m : ~m} + (x[8] && x[10:8] != 3'h7);
      if (x[10:8] == 3'h7) s = {1'b0, c & m};
      b = (x[5:4] == 2'h0) ? cin : (x[5:4] == 2'h3) ? ~cin : x[5];
      b = b ^ s[16];
      case (x[7:6])
        2'h0: model = {b, s[15:0]};
        2'h1: model = {s[15], s[14:0], b};
        2'h2: model = {s[0], b, s[15:1]};
        default: model = {b, s[7:0], s[15:8]};
      endcase
    end
  endfunction
  // Watchdog well beyond the few hundred cycles the tests need
  initial begin
    repeat (20000) @(posedge clk_sys);
    err_total = err_total + 1;
    report_and_stop;
  end

  // --------------------------------------------------------------
  // Test sequence
  // --------------------------------------------------------------
  initial begin
    {err_total, checked, cy, present, waitStart, word} = 0;
    {readModifyWriteStretch, outputStretch, slowChannelStretch} = 3'h0;
    {extendPeriod, port1ReadAddr, port1WriteAddr, port2Addr} = 10'h000;
    reset = 1'b1;
    idle;
    repeat (9) @(negedge clk_sys);
    reset = 1'b0;
    check(dataBusOutN, 16'hffff);
    check({15'h0000, carry}, 16'h0000);
    // Every entry written, then all read back; two entries are 15 bits
    for (i = 0; i < 8; i = i + 1) begin
      rv[i] = masked(i, 16'hc3a5 + i * 16'h0101);
      write1(i, 16'hc3a5 + i * 16'h0101);
    end
    for (i = 0; i < 8; i = i + 1)
      readback(i, rv[i]);
    // Processor functions written back through port two
    for (i = 0; i < 4; i = i + 1) begin
      {port1ReadEn, port1ReadAddr, port2ReadEn, port2WriteEn} = 6'h33;
      {port2Addr, procFunc} = {i[2:0], i[1:0]};
      @(negedge clk_sys);
      idle;
      r[15:0] = (i == 3) ? rv[4] : rv[i] + (i == 1) - (i == 2);
      rv[i] = masked(i, r[15:0]);
      readback(i, rv[i]);
    end
    // Every operation, carry code and shift; some without carry load
    write1(3'h4, 16'h9c35);
    for (i = 0; i < 12; i = i + 1) begin
      ir = {5'h00, i[2:0], (i > 7) ? i[1:0] : 2'h0, i[1:0] ^ i[3:2], 4'h0};
      set_ir(ir);
      write1(3'h5, 16'h7a5b);
      {arithLogicClassInstr, port1ReadEn, port1ReadAddr} = 5'h1c;
      {port2ReadEn, port2WriteEn, port2Addr} = 5'h1d;
      carryLoad = (i % 3) != 2;
      @(negedge clk_sys);
      idle;
      r = model(ir, 16'h9c35, 16'h7a5b, cy);
      if (i % 3 != 2) cy = r[16];
      readback(3'h5, r[15:0]);
      check({15'h0000, carry}, {15'h0000, cy});
    end
    // Displacement sign-extended in the address state
    for (i = 0; i < 2; i = i + 1) begin
      ir = i ? 16'h0f45 : 16'h0f85;
      set_ir(ir);
      {effectiveAddrState, inputMuxEn, port1WriteEn} = 3'h7;
      port1WriteAddr = 3'h6;
      @(negedge clk_sys);
      idle;
      readback(3'h6, {{8{ir[7]}}, ir[7:0]});
    end
    // State clock periods for each request mix
    for (i = 0; i < 6; i = i + 1) begin
      case (i)
        0: {extendPeriod, slowChannelStretch} = 2'h0;
        1: readModifyWriteStretch = 1'b1;
        2: {readModifyWriteStretch, outputStretch} = 2'h1;
        3: {outputStretch, slowChannelStretch} = 2'h1;
        4: {slowChannelStretch, extendPeriod} = 2'h1;
        default: readModifyWriteStretch = 1'b1;
      endcase
      period(1'b1, 16'h0001);
      period(1'b0, 16'h0001);
      check(n, i == 0 ? 6 : i < 4 ? 8 : i == 4 ? 12 : 16);
    end
    {readModifyWriteStretch, extendPeriod} = 2'h0;
    // Slow memory holds the generator frozen for over three plain periods
    period(1'b1, 16'h0001);
    waitStart = 1'b1;
    @(negedge clk_sys);
    waitStart = 1'b0;
    period(1'b0, 16'h0002);
    check({15'h0000, n > 22 && n < 28}, 16'h0001);
    report_and_stop;
  end
endmodule
